/* File: core/uspb_core.sv */
`timescale 1ns/1ps
`default_nettype none
module uspb_core #(
    parameter int DEPTH = uspb_pkg::DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Controller link pins
    input wire logic byte_strobe_n,
    input wire logic [7:0] data_in,
    input wire logic xmit_trig_n,
    input wire logic [2:0] set_sel_pins,
    output logic rdy_load,
    output logic amp_en,
    // Byte stream to modulator
    output logic mod_valid,
    output uspb_pkg::uspb_mod_s mod_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    // Refuse a buffer that is not a power of two
    if (DEPTH != (1 << AW) || DEPTH < 16 || DEPTH > 4096) begin : g_chk
        $error("DEPTH must be a power of two from 16 to 4096");
    end

    // ==========================================
    // Block state, except the pin synchroniser and amplifier lag registers
    typedef struct packed {
        logic [8:0] ctrl;
        logic [7:0] refill;
        logic [15:0] on_lag;
        logic [15:0] off_lag;
        logic [19:0] pktlen;
        logic [15:0] byteper;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic strb_prev;
        logic trig_prev;
        logic [DEPTH-1:0][7:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] cnt;
        uspb_pkg::uspb_tx_e st;
        logic [15:0] div;
        logic [1:0] lowcnt;
        logic [19:0] sent;
        logic load;
        logic mod_valid;
        uspb_pkg::uspb_mod_s mod;
        uspb_pkg::uspb_enc_s work_enc;
        logic [2:0] work_set;
    } uspb_state_s;
    uspb_state_s q, d;

    // Synchronised pins
    logic strb_s;
    logic trig_s;
    logic [2:0] sel_s;
    logic [7:0] data_s;
    // Derived events
    logic mode;
    logic strb_fall;
    logic trig_fall;
    logic tick;
    logic push;
    logic pop;
    logic done;
    logic [2:0] sel_eff;
    logic [CW-1:0] vacancy;
    logic [CW-1:0] thr8;
    logic [15:0] div_rld;

    // Byte-wise merge of a write
    function automatic logic [31:0] uspb_merge(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================
    // Pin synchronisers, strobe and data share latency
    uspb_sync2 #(
        .W(13),
        .RST(13'h1800)
    ) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .din({byte_strobe_n, xmit_trig_n, set_sel_pins, data_in}),
        .dout({strb_s, trig_s, sel_s, data_s})
    );

    // Amplifier enable with turn-on and turn-off lag
    uspb_lag u_lag (
        .clk(clk),
        .arst_n(arst_n),
        .raw(q.st != uspb_pkg::TX_IDLE),
        .on_lag(q.on_lag),
        .off_lag(q.off_lag),
        .out(amp_en)
    );

    // ==========================================
    // Event decode
    assign mode = q.ctrl[uspb_pkg::CTRL_MODE];
    assign strb_fall = q.strb_prev && !strb_s;
    assign trig_fall = q.trig_prev && !trig_s;
    assign tick = (q.div == 16'h0000);
    assign push = mode && strb_fall && (q.cnt != FULL);
    assign pop = mode && (q.st == uspb_pkg::TX_RUN) && tick && (q.cnt != '0);
    assign done = pop && ((q.sent + 20'h00001) == q.pktlen);
    assign sel_eff = sel_s | q.ctrl[uspb_pkg::CTRL_SEL +: 3];
    assign vacancy = FULL - q.cnt;
    assign thr8 = CW'({q.refill, 3'h0});
    assign div_rld = (q.byteper == 16'h0000) ? 16'h0000 : q.byteper - 16'h0001;

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        d.mod_valid = 1'b0;
        // Write address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_ok = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_ok = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // Both halves present: commit write
        if (q.aw_ok && q.w_ok && !q.bvalid) begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = uspb_pkg::RESP_OKAY;
            case (q.aw_addr)
                uspb_pkg::OFS_CTRL: begin
                    d.ctrl = 9'(uspb_merge({23'h0, q.ctrl}, q.w_data, q.w_strb));
                end
                uspb_pkg::OFS_REFILL: begin
                    d.refill = 8'(uspb_merge({24'h0, q.refill}, q.w_data, q.w_strb));
                end
                uspb_pkg::OFS_ON_LAG: begin
                    d.on_lag = 16'(uspb_merge({16'h0, q.on_lag}, q.w_data, q.w_strb));
                end
                uspb_pkg::OFS_OFF_LAG: begin
                    d.off_lag = 16'(uspb_merge({16'h0, q.off_lag}, q.w_data, q.w_strb));
                end
                uspb_pkg::OFS_PKTLEN: begin
                    d.pktlen = 20'(uspb_merge({12'h0, q.pktlen}, q.w_data, q.w_strb));
                end
                uspb_pkg::OFS_BYTEPER: begin
                    d.byteper = 16'(uspb_merge({16'h0, q.byteper}, q.w_data, q.w_strb));
                end
                // Status is read-only, rest unmapped
                default: d.bresp = uspb_pkg::RESP_SLVERR;
            endcase
        end
        // Read answer one cycle after address
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = uspb_pkg::RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                uspb_pkg::OFS_CTRL: d.rdata[8:0] = q.ctrl;
                uspb_pkg::OFS_REFILL: d.rdata[7:0] = q.refill;
                uspb_pkg::OFS_ON_LAG: d.rdata[15:0] = q.on_lag;
                uspb_pkg::OFS_OFF_LAG: d.rdata[15:0] = q.off_lag;
                uspb_pkg::OFS_PKTLEN: d.rdata[19:0] = q.pktlen;
                uspb_pkg::OFS_BYTEPER: d.rdata[15:0] = q.byteper;
                uspb_pkg::OFS_STATUS: begin
                    // Fill level and live state
                    d.rdata[CW-1:0] = q.cnt;
                    d.rdata[uspb_pkg::ST_LOAD] = q.load;
                    d.rdata[uspb_pkg::ST_AMP] = amp_en;
                    d.rdata[uspb_pkg::ST_BUSY] = (q.st != uspb_pkg::TX_IDLE);
                    d.rdata[uspb_pkg::ST_SET +: 3] = q.work_set;
                    d.rdata[uspb_pkg::ST_ENC +: 3] = q.work_enc;
                end
                default: d.rresp = uspb_pkg::RESP_SLVERR;
            endcase
        end
        // Edge history of synchronised pins
        d.strb_prev = strb_s;
        d.trig_prev = trig_s;
        // Byte-rate divider, restarts while idle
        if ((q.st == uspb_pkg::TX_IDLE) || tick) begin
            d.div = div_rld;
        end else begin
            d.div = q.div - 16'h0001;
        end
        // Buffer write side
        if (push) begin
            d.mem[q.wptr] = data_s;
            d.wptr = q.wptr + AW'(1);
        end
        // Buffer read side feeds the modulator
        if (pop) begin
            d.mod.data = q.mem[q.rptr];
            d.mod.enc = q.work_enc;
            d.mod.set = q.work_set;
            d.mod_valid = 1'b1;
            d.rptr = q.rptr + AW'(1);
            d.sent = q.sent + 20'h00001;
        end
        d.cnt = q.cnt + CW'(push) - CW'(pop);
        // Transmit sequencer
        case (q.st)
            uspb_pkg::TX_IDLE: begin
                d.sent = 20'h00000;
                if (!mode && !trig_s) begin
                    // Slot lasts while trigger is low
                    d.st = uspb_pkg::TX_RUN;
                end else if (mode && trig_fall) begin
                    // Trigger only starts the packet
                    if (q.pktlen != 20'h00000) begin
                        d.st = uspb_pkg::TX_RUN;
                    end
                    if (q.ctrl[uspb_pkg::CTRL_VALID] && sel_eff < 3'(uspb_pkg::NUM_SETS)) begin
                        d.work_set = sel_eff;
                        d.work_enc = q.ctrl[uspb_pkg::CTRL_BYPASS] ? '0
                            : q.ctrl[uspb_pkg::CTRL_ENC +: 3];
                    end
                end
            end
            uspb_pkg::TX_RUN: begin
                if (!mode) begin
                    if (trig_s) begin
                        d.st = uspb_pkg::TX_IDLE;
                    end else if (tick) begin
                        // Ask for the next byte
                        d.st = uspb_pkg::TX_REQ;
                        d.lowcnt = 2'h0;
                    end
                end else if (done) begin
                    d.st = uspb_pkg::TX_IDLE;
                end
            end
            uspb_pkg::TX_REQ: begin
                d.lowcnt = q.lowcnt + 2'h1;
                if (q.lowcnt == 2'(uspb_pkg::LOAD_LOW_CYC - 1)) begin
                    // Take the byte as request rises, encoder bypassed
                    d.st = trig_s ? uspb_pkg::TX_IDLE : uspb_pkg::TX_RUN;
                    d.mod.data = data_s;
                    d.mod.enc = '0;
                    d.mod.set = q.work_set;
                    d.mod_valid = 1'b1;
                end
            end
            default: d.st = uspb_pkg::TX_IDLE;
        endcase
        // Load request per mode
        if (!mode) begin
            d.load = (d.st != uspb_pkg::TX_REQ);
        end else if (q.cnt == FULL) begin
            d.load = 1'b0;
        end else if (vacancy > thr8) begin
            d.load = 1'b1;
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.ctrl <= uspb_pkg::CTRL_RST;
            q.refill <= uspb_pkg::REFILL_RST;
            q.on_lag <= uspb_pkg::LAG_RST;
            q.off_lag <= uspb_pkg::LAG_RST;
            q.pktlen <= uspb_pkg::PKTLEN_RST;
            q.byteper <= uspb_pkg::BYTEPER_RST;
            q.strb_prev <= 1'b1;
            q.trig_prev <= 1'b1;
            q.st <= uspb_pkg::TX_IDLE;
            q.load <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Outputs
    assign s_axi_awready = !q.aw_ok && !q.bvalid;
    assign s_axi_wready = !q.w_ok && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign rdy_load = q.load;
    assign mod_valid = q.mod_valid;
    assign mod_out = q.mod;

    // ==========================================
    // Checks
    refill_full_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode && q.cnt == FULL) |=> !rdy_load || !mode)
        else $error("Load request still high with full buffer");
    refill_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode && q.cnt != FULL && vacancy > thr8) |=> rdy_load || !mode)
        else $error("Load request not raised with vacancy");
    req_low_len_a: assert property (@(posedge clk) disable iff (!arst_n)
        ($fell(rdy_load) && !mode) |-> !rdy_load [*4] ##1 rdy_load)
        else $error("Direct byte request low time wrong");
    strobe_store_a: assert property (@(posedge clk) disable iff (!arst_n)
        (push && !pop) |=> q.cnt == $past(q.cnt) + CW'(1))
        else $error("Strobed byte not stored");
    direct_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        !mode |=> $stable(q.cnt))
        else $error("Buffer moved in direct mode");
    burst_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode && q.st == uspb_pkg::TX_IDLE && trig_fall && q.pktlen != 20'h0)
        |=> q.st == uspb_pkg::TX_RUN)
        else $error("Trigger did not start packet");
    burst_end_a: assert property (@(posedge clk) disable iff (!arst_n)
        done |=> q.st == uspb_pkg::TX_IDLE ##1 !mod_valid)
        else $error("Packet did not end at its length");
    set_copy_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mode && q.st == uspb_pkg::TX_IDLE && trig_fall && q.ctrl[uspb_pkg::CTRL_VALID]
        && sel_eff < 3'(uspb_pkg::NUM_SETS)) |=> q.work_set == $past(sel_eff))
        else $error("Selected set not copied");
    set_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !q.ctrl[uspb_pkg::CTRL_VALID] |=> $stable(q.work_set) && $stable(q.work_enc))
        else $error("Set copied while valid bit clear");
    enc_bypass_a: assert property (@(posedge clk) disable iff (!arst_n)
        (mod_valid && !$past(mode)) |-> mod_out.enc == '0)
        else $error("Direct bytes marked for encoding");
endmodule
`default_nettype wire

/* File: core/uspb_lag.sv */
`timescale 1ns/1ps
`default_nettype none
module uspb_lag (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw level and lags in cycles
    input wire logic raw,
    input wire logic [15:0] on_lag,
    input wire logic [15:0] off_lag,
    // Delayed level
    output logic out
);
    // Output level and wait counter
    typedef struct packed {
        logic out;
        logic [15:0] cnt;
    } uspb_lag_s;
    uspb_lag_s q, d;

    // ==========================================
    // Follow raw once it has differed long enough
    always_comb begin
        d = q;
        if (raw != q.out) begin
            // Separate lag for each direction
            if (q.cnt >= (raw ? on_lag : off_lag)) begin
                d.out = raw;
                d.cnt = 16'h0000;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end else begin
            // Glitch shorter than the lag is dropped
            d.cnt = 16'h0000;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out = q.out;

    // ==========================================
    // Checks
    amp_on_lag_a: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(out) |-> $past(raw) && $past(q.cnt) >= $past(on_lag))
        else $error("Enable rose before on lag elapsed");
    amp_off_lag_a: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(out) |-> !$past(raw) && $past(q.cnt) >= $past(off_lag))
        else $error("Enable fell before off lag elapsed");
endmodule
`default_nettype wire

/* File: core/uspb_pkg.sv */
package uspb_pkg;
    // ==========================================
    // Buffer geometry
    localparam int DEPTH = 2048;
    localparam int NUM_SETS = 6;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REFILL = 8'h04;
    localparam logic [7:0] OFS_ON_LAG = 8'h08;
    localparam logic [7:0] OFS_OFF_LAG = 8'h0C;
    localparam logic [7:0] OFS_PKTLEN = 8'h10;
    localparam logic [7:0] OFS_BYTEPER = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Control field positions
    localparam int CTRL_MODE = 0;
    localparam int CTRL_VALID = 1;
    localparam int CTRL_SEL = 2;
    localparam int CTRL_ENC = 5;
    localparam int CTRL_BYPASS = 8;
    // Status field positions
    localparam int ST_LOAD = 16;
    localparam int ST_AMP = 17;
    localparam int ST_BUSY = 18;
    localparam int ST_SET = 20;
    localparam int ST_ENC = 24;
    // Reset values
    localparam logic [8:0] CTRL_RST = 9'h0E1;
    localparam logic [7:0] REFILL_RST = 8'h10;
    localparam logic [15:0] LAG_RST = 16'h0000;
    localparam logic [19:0] PKTLEN_RST = 20'h00000;
    localparam logic [15:0] BYTEPER_RST = 16'h0010;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int LOAD_LOW_NS = 160;
    localparam int LOAD_LOW_CYC = (LOAD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_MAX_HZ = 5000000;
    // ==========================================
    // Types
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_RUN = 3'h2,
        TX_REQ = 3'h4
    } uspb_tx_e;
    typedef struct packed {
        logic pre_en;
        logic rs_en;
        logic rand_en;
    } uspb_enc_s;
    typedef struct packed {
        logic [7:0] data;
        uspb_enc_s enc;
        logic [2:0] set;
    } uspb_mod_s;
endpackage

/* File: core/uspb_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module uspb_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pins in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Two stage chain
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } uspb_sync_s;
    uspb_sync_s q, d;

    // ==========================================
    // Next state: first stage feeds only the second
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q.s1 <= RST;
            q.s2 <= RST;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule
`default_nettype wire

/* File: tb/test_upstream_burst_data_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
// ==========================
// Bench top
module test_upstream_burst_data_interface;
    localparam int DP = 16; // Shrunk buffer
    localparam logic [1:0] OK = uspb_pkg::RESP_OKAY;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic trig_n = 1'h1;
    logic direct_on = 1'h0;
    logic [2:0] pins = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, rdy_load, amp_en, mod_valid, strobe_n;
    logic [1:0] bresp, rresp;
    logic [7:0] din;
    logic [31:0] rdata, rd;
    uspb_pkg::uspb_mod_s mod_out;
    uspb_pkg::uspb_mod_s got[$];
    int err_total = 0;
    int check_count = 0;
    int low_n = 0;
    initial forever #20 clk = ~clk;
    uspb_core #(.DEPTH(DP)) dut (
        .clk(clk), .arst_n(arst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .byte_strobe_n(strobe_n), .data_in(din), .xmit_trig_n(trig_n),
        .set_sel_pins(pins), .rdy_load(rdy_load), .amp_en(amp_en),
        .mod_valid(mod_valid), .mod_out(mod_out));
    uspb_mac_model mac (.rdy_load(rdy_load), .direct_on(direct_on),
        .byte_strobe_n(strobe_n), .data_in(din));
    // Collect bytes, time direct-mode requests
    always @(posedge clk) begin
        if (mod_valid === 1'h1) got.push_back(mod_out);
        if (direct_on && rdy_load === 1'h0) low_n <= low_n + 1;
        if (direct_on && rdy_load === 1'h1 && low_n != 0) begin
            `CHK(low_n, uspb_pkg::LOAD_LOW_CYC)
            low_n <= 0;
        end
    end
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // AXI4-Lite write, answer awaited
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit fin;
        logic ta, tw, tk;
        fin = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (int n = 0; n < 50 && !fin; n++) begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tk = bvalid;
            @(posedge clk);
            if (ta) awvalid <= 1'h0;
            if (tw) wvalid <= 1'h0;
            if (tk) begin
                bready <= 1'h0;
                fin = 1;
                `CHK(bresp, er)
            end
        end
        if (!fin) begin
            err_total++;
            report_and_stop();
        end
    endtask
    // AXI4-Lite read into rd
    task automatic rdr(input logic [7:0] a, input logic [1:0] er);
        bit fin;
        logic ta, tk;
        fin = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (int n = 0; n < 50 && !fin; n++) begin
            @(negedge clk);
            ta = arvalid & arready;
            tk = rvalid;
            rd = rdata;
            @(posedge clk);
            if (ta) arvalid <= 1'h0;
            if (tk) begin
                rready <= 1'h0;
                fin = 1;
                `CHK(rresp, er)
            end
        end
        if (!fin) begin
            err_total++;
            report_and_stop();
        end
    endtask
    task automatic wait_got(input int nb);
        for (int k = 0; k < 2000 && got.size() < nb; k++) @(posedge clk);
        `CHK(got.size() >= nb, 1'h1)
        if (got.size() < nb) report_and_stop();
    endtask
    // Burst packet: preload, trigger, refill, compare
    // Expected set and encoder flags are those of the active working set
    task automatic run_pkt(input logic [31:0] ctrl, input int nb, input logic [2:0] st,
        input logic [2:0] en);
        uspb_pkg::uspb_mod_s e;
        wr(uspb_pkg::OFS_CTRL, ctrl, OK);
        wr(uspb_pkg::OFS_PKTLEN, nb, OK);
        got.delete();
        for (int i = 0; i < nb && i < DP; i++) mac.send(8'h30 + i[7:0]);
        if (nb > DP) begin
            mac.send(8'hEE); // Dropped, buffer full
            rdr(uspb_pkg::OFS_STATUS, OK);
            `CHK({rd[16], rd[11:0]}, {1'h0, 12'h010})
        end
        @(posedge clk);
        trig_n <= 1'h0;
        repeat (4) @(posedge clk);
        trig_n <= 1'h1;
        repeat (16) @(negedge clk);
        `CHK(amp_en, 1'h0)
        repeat (40) @(negedge clk);
        `CHK(amp_en, 1'h1)
        if (nb > DP) begin
            for (int k = 0; k < 1000 && rdy_load !== 1'h1; k++) @(posedge clk);
            `CHK(rdy_load, 1'h1)
            for (int i = DP; i < nb; i++) mac.send(8'h30 + i[7:0]);
        end
        wait_got(nb);
        @(negedge clk);
        `CHK(amp_en, 1'h1)
        repeat (12) @(negedge clk);
        `CHK({amp_en, rdy_load}, 2'h1)
        for (int i = 0; i < nb; i++) begin
            e = '{data: 8'h30 + i[7:0], enc: en, set: st};
            `CHK(got[i], e)
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'h1;
        @(negedge clk);
        `CHK({rdy_load, amp_en, mod_valid}, 3'h4)
        rdr(uspb_pkg::OFS_CTRL, OK);
        `CHK(rd, 32'h0E1)
        rdr(uspb_pkg::OFS_STATUS, OK);
        `CHK(rd & 32'h1_0FFF, 32'h1_0000)
        rdr(8'h1C, uspb_pkg::RESP_SLVERR);
        `CHK(rd, 32'h0)
        wr(uspb_pkg::OFS_STATUS, 32'h0, uspb_pkg::RESP_SLVERR);
        wr(uspb_pkg::OFS_REFILL, 32'h1, OK);
        wr(uspb_pkg::OFS_BYTEPER, 32'h14, OK);
        wr(uspb_pkg::OFS_ON_LAG, 32'h28, OK);
        wr(uspb_pkg::OFS_OFF_LAG, 32'h3, OK);
        run_pkt(32'hAF, 24, 3'h3, 3'h5);
        @(posedge clk) pins <= 3'h5;
        run_pkt(32'h143, 4, 3'h5, 3'h0);
        @(posedge clk) pins <= 3'h2;
        run_pkt(32'h21, 4, 3'h5, 3'h0);
        @(posedge clk) pins <= 3'h0;
        // Direct pull with handshake per byte
        wr(uspb_pkg::OFS_CTRL, 32'h0, OK);
        wr(uspb_pkg::OFS_BYTEPER, 32'h8, OK);
        wr(uspb_pkg::OFS_ON_LAG, 32'h2, OK);
        direct_on <= 1'h1;
        got.delete();
        trig_n <= 1'h0;
        wait_got(5);
        @(negedge clk);
        `CHK(amp_en, 1'h1)
        @(posedge clk) trig_n <= 1'h1;
        repeat (30) @(negedge clk);
        `CHK(amp_en, 1'h0)
        for (int i = 0; i < 5; i++) `CHK({got[i].data, got[i].enc}, {i[7:0], 3'h0})
        rdr(uspb_pkg::OFS_STATUS, OK);
        `CHK({rd[26:16], rd[11:0]}, {3'h0, 1'h0, 3'h5, 4'h1, 12'h0})
        report_and_stop();
    end
endmodule
`default_nettype wire

/* File: tb/uspb_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Controller side of the byte link
module uspb_mac_model (
    // Request from the block, direct-mode flag from the bench
    input wire logic rdy_load,
    input wire logic direct_on,
    // Link pins
    output logic byte_strobe_n,
    output logic [7:0] data_in
);
    logic [7:0] nxt_q = 8'h00; // Next direct-mode byte
    initial begin
        byte_strobe_n = 1'h1;
        data_in = 8'hA5;
    end
    // One byte per 320 ns strobe period
    // Pin edges sit 10 ns off the core clock edges to avoid sampling races
    task automatic send(input logic [7:0] b);
        #10 data_in = b;
        #80 byte_strobe_n = 1'h0;
        #160 byte_strobe_n = 1'h1;
        data_in = ~b; // Stale after hold
        #70;
    endtask
    // Direct mode: byte ready at once
    always @(negedge rdy_load) begin
        if (direct_on) begin
            #10 data_in = nxt_q;
            nxt_q = nxt_q + 8'h01;
        end
    end
    // Direct mode: byte goes stale after the take
    always @(posedge rdy_load) begin
        if (direct_on) begin
            #70 data_in = ~data_in;
        end
    end
endmodule
`default_nettype wire
